// ---- cache_id_register_bank.sv ----
// Cache identification register bank reached by coprocessor moves.
// Assumes a decoded coprocessor request each cycle, synchronous to core_clk.
//
// Behaviour
// - ISA attributes word five reads zero.
// - ISA attributes words six, seven read zero.
// - Privileged only; one copy for both states.
// - Cache size word follows selected cache.
// - Instruction cache attribute nibble is 0010.
// - Data cache attribute nibble is 0111.
// - Data set count is sets minus one.
// - Instruction set count per size table.
// - Associativity four-way data, two-way instruction.
// - Line length field reads one.
// - Cache level word at opc1 1, opc2 1.
// - Unification and coherency levels read 001.
// - Level one reports split caches.
// - Levels two to seven and top bits zero.
// - Select bit one picks instruction cache.
// - Select level field reads zero, ignores writes.
`timescale 1ns/1ps
`default_nettype none

module cache_id_register_bank
  import cache_id_pkg::*;
#(
  parameter int ICACHE_KB = 16,
  parameter int DCACHE_KB = 16
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire cp_req_s     req,
  input  wire logic [31:0] wr_data,
  output var  cp_rsp_s     rsp
);

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  function automatic int size_shift(input int kb);
    case (kb)
      4:       size_shift = 0;
      8:       size_shift = 1;
      16:      size_shift = 2;
      32:      size_shift = 3;
      64:      size_shift = 4;
      default: size_shift = -1;
    endcase
  endfunction : size_shift

  // Sets double with each size step, so sets minus one shifts in ones from the
  // right; one formula serves both caches from their 4 KB base values.
  function automatic logic [14:0] sets_minus_one(input logic [14:0] base, input int kb);
    int shift;
    shift = size_shift(kb);
    sets_minus_one = 15'((32'(base) << shift) | ((32'h0000_0001 << shift) - 32'h0000_0001));
  endfunction : sets_minus_one

  // Only the five supported sizes have a set-count encoding; any other value
  // would give a silently wrong word, so elaboration stops instead.
  if (size_shift(ICACHE_KB) < 0) begin : g_bad_icache_kb
    $error("ICACHE_KB must be 4, 8, 16, 32 or 64");
  end
  if (size_shift(DCACHE_KB) < 0) begin : g_bad_dcache_kb
    $error("DCACHE_KB must be 4, 8, 16, 32 or 64");
  end

  localparam logic [14:0] DSETS = sets_minus_one(DSETS_4KB, DCACHE_KB);
  localparam logic [14:0] ISETS = sets_minus_one(ISETS_4KB, ICACHE_KB);

  // ----------------------------------------------------------------
  // Selection bit
  // ----------------------------------------------------------------
  // Only the select bit is held; the level field has no storage at all, so it
  // reads zero and drops whatever a write carries in bits 3 to 1.
  logic instr_not_data_select_q;
  logic instr_not_data_select_d;

  // Coordinate decode. Every word sits at one fixed place in the coprocessor
  // space, all of them under crn c0.
  wire crn_id    = req.crn == CRN_ID;
  wire crm_isa   = req.crm == CRM_ISA;
  wire crm_cache = req.crm == CRM_CACHE;
  wire hit_isa   = req.opc1 == OPC1_ISA && crn_id && crm_isa;
  wire hit_cache = req.opc1 == OPC1_CACHE && crn_id && crm_cache;
  wire hit_sel   = req.opc1 == OPC1_SEL && crn_id && crm_cache && req.opc2 == OPC2_SEL;
  wire hit_isa5  = hit_isa && req.opc2 == OPC2_ISA5;
  wire hit_isa67 = hit_isa && (req.opc2 == OPC2_ISA6 || req.opc2 == OPC2_ISA7);
  wire hit_size  = hit_cache && req.opc2 == OPC2_SIZE;
  wire hit_level = hit_cache && req.opc2 == OPC2_LEVEL;
  wire hit_ident = hit_isa5 || hit_isa67 || hit_size || hit_level;
  wire hit_any   = hit_ident || hit_sel;

  // Access qualifiers.
  wire access    = req.rd || req.wr;
  wire read_ok   = req.rd && req.priv && hit_any;
  wire sel_write = req.wr && req.priv && hit_sel;

  // A write that is refused or aimed at an identification word leaves the bit.
  assign instr_not_data_select_d = sel_write ? wr_data[SEL_IND_BIT] : instr_not_data_select_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      instr_not_data_select_q <= SEL_RESET;
    end else if (clk_en) begin
      instr_not_data_select_q <= instr_not_data_select_d;
    end
  end

  // ----------------------------------------------------------------
  // Word assembly
  // ----------------------------------------------------------------
  wire is_icache = instr_not_data_select_q;

  // Cache size word fields for whichever cache the select bit picks.
  wire [3:0]  attr_nibble = is_icache ? ICACHE_ATTR : DCACHE_ATTR;
  wire [14:0] set_count   = is_icache ? ISETS : DSETS;
  wire [9:0]  assoc_ways  = is_icache ? ICACHE_ASSOC : DCACHE_ASSOC;
  wire [2:0]  line_length = LINE_LEN_VAL;

  wire [31:0] size_word = {attr_nibble, set_count, assoc_ways, line_length};

  // Cache level word fields; only level one holds a cache.
  wire [2:0]  unify_level_uniproc      = LEVEL_ONE;
  wire [2:0]  coherency_level          = LEVEL_ONE;
  wire [2:0]  unify_level_inner_shared = LEVEL_ONE;
  wire [17:0] absent_level_types       = 18'h0_0000;
  wire [2:0]  level_one_type           = CL1_SPLIT;

  wire [31:0] level_word = {2'h0, unify_level_uniproc, coherency_level,
                            unify_level_inner_shared, absent_level_types, level_one_type};

  wire [31:0] sel_word = {31'h0000_0000, instr_not_data_select_q};

  // Isa attribute words five to seven have no fields and read zero.
  wire [31:0] rd_word = hit_size  ? size_word
                      : hit_level ? level_word
                      : hit_sel   ? sel_word
                      : ZERO_WORD;

  // Unprivileged accesses and unknown coordinates raise undefined.
  wire bad = !req.priv || !hit_any;

  // ----------------------------------------------------------------
  // Registered response
  // ----------------------------------------------------------------
  // The answer comes one enabled edge after the request and stands until the
  // next enabled edge; the core takes it at once, so no handshake is kept.
  // A write to an identification word is acknowledged but stores nothing,
  // and its answer carries zero data.
  cp_rsp_s rsp_d;

  assign rsp_d = '{valid: access,
                   undef: access && bad,
                   data:  read_ok ? rd_word : ZERO_WORD};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else if (clk_en) begin
      rsp <= rsp_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // All checks run in the one core_clk domain and sleep through reset.

  // Set counts straight from the size table, kept apart from the shift
  // formula above so that a slip in either one shows up.
  function automatic logic [14:0] dsets_table(input int kb);
    case (kb)
      4:       dsets_table = 15'h001F;
      8:       dsets_table = 15'h003F;
      16:      dsets_table = 15'h007F;
      32:      dsets_table = 15'h00FF;
      64:      dsets_table = 15'h01FF;
      default: dsets_table = 15'h0000;
    endcase
  endfunction : dsets_table

  function automatic logic [14:0] isets_table(input int kb);
    case (kb)
      4:       isets_table = 15'h003F;
      8:       isets_table = 15'h007F;
      16:      isets_table = 15'h00FF;
      32:      isets_table = 15'h01FF;
      64:      isets_table = 15'h03FF;
      default: isets_table = 15'h0000;
    endcase
  endfunction : isets_table

  localparam logic [14:0] DSETS_EXP = dsets_table(DCACHE_KB);
  localparam logic [14:0] ISETS_EXP = isets_table(ICACHE_KB);

  if (DSETS != DSETS_EXP || ISETS != ISETS_EXP) begin : g_sets_check
    $error("set count formula disagrees with the size table");
  end

  // Isa attribute words. They read zero from any mode; only a privileged
  // read is answered without undefined.
  a_isa_words_zero: assert property (
      clk_en && req.rd && (hit_isa5 || hit_isa67)
      |=> rsp.data == 32'h0000_0000)
    else $error("isa attribute word not zero");

  a_isa_answered: assert property (
      clk_en && req.rd && req.priv && (hit_isa5 || hit_isa67)
      |=> rsp.valid && !rsp.undef)
    else $error("isa attribute read refused");

  // Cache size word. The select bit is looked at in the cycle the read is
  // taken, so a later select write cannot change an answer in flight.
  a_icache_attr: assert property (
      clk_en && req.rd && req.priv && hit_size && is_icache
      |=> rsp.data[31:28] == 4'h2)
    else $error("instruction cache attributes wrong");

  a_dcache_attr: assert property (
      clk_en && req.rd && req.priv && hit_size && !is_icache
      |=> rsp.data[31:28] == 4'h7)
    else $error("data cache attributes wrong");

  a_attr_flags: assert property (
      clk_en && req.rd && req.priv && hit_size
      |=> !rsp.data[31] && rsp.data[29] && (rsp.data[30] == rsp.data[28]))
    else $error("cache attribute flags wrong");

  a_assoc_field: assert property (
      clk_en && req.rd && req.priv && hit_size
      |=> rsp.data[12:3] == ($past(is_icache) ? 10'h001 : 10'h003) && rsp.data[2:0] == 3'h1)
    else $error("associativity or line length wrong");

  a_line_length: assert property (
      clk_en && req.rd && req.priv && hit_size
      |=> rsp.data[2:0] == 3'h1)
    else $error("line length wrong");

  a_sets_field: assert property (
      clk_en && req.rd && req.priv && hit_size
      |=> rsp.data[27:13] == ($past(is_icache) ? ISETS_EXP : DSETS_EXP))
    else $error("set count wrong");

  // Cache level word. It never depends on the select bit.
  a_level_word: assert property (
      clk_en && req.rd && req.priv && hit_level
      |=> rsp.data == 32'h0920_0003)
    else $error("cache level word wrong");

  a_level_unify: assert property (
      clk_en && req.rd && req.priv && hit_level
      |=> rsp.data[29:21] == 9'h049)
    else $error("unification or coherency level wrong");

  a_level_types: assert property (
      clk_en && req.rd && req.priv && hit_level
      |=> rsp.data[20:0] == 21'h00_0003)
    else $error("cache type fields wrong");

  a_level_reserved: assert property (
      clk_en && req.rd && req.priv && hit_level
      |=> rsp.data[31:30] == 2'h0)
    else $error("cache level top bits not zero");

  // Privilege and decode refusals. A refused access is still answered, so
  // the core never waits; it sees undefined with zero data, and a refused
  // write leaves the select bit as it was.
  a_priv_only_undef: assert property (
      clk_en && access && !req.priv
      |=> rsp.valid && rsp.undef && rsp.data == 32'h0000_0000)
    else $error("unprivileged access not refused");

  a_unpriv_no_store: assert property (
      clk_en && req.wr && !req.priv
      |=> $stable(instr_not_data_select_q))
    else $error("unprivileged write changed selection");

  a_unmapped_undef: assert property (
      clk_en && access && !hit_any
      |=> rsp.valid && rsp.undef)
    else $error("unmapped access not refused");

  a_undef_data_zero: assert property (
      rsp.undef
      |-> rsp.valid && rsp.data == 32'h0000_0000)
    else $error("undefined answer carries data");

  // Selection bit. A select write takes effect at once, so a size read in
  // the very next cycle already describes the newly picked cache; the
  // level field stays zero whatever is written.
  a_select_follows: assert property (
      clk_en && sel_write ##1 clk_en && req.rd && req.priv && hit_size
      |=> rsp.data[31:28] == ($past(wr_data[0], 2) ? 4'h2 : 4'h7))
    else $error("size word ignores selection");

  a_select_stores: assert property (
      clk_en && sel_write
      |=> instr_not_data_select_q == $past(wr_data[SEL_IND_BIT]))
    else $error("select write not stored");

  a_select_level_zero: assert property (
      clk_en && req.rd && req.priv && hit_sel
      |=> rsp.data[31:1] == 31'h0000_0000)
    else $error("select level field not zero");

  // Writes and the response handshake. Every taken access gets exactly one
  // answer; an idle cycle answers nothing, and a low enable freezes both the
  // answer and the select bit.
  a_write_no_effect: assert property (
      clk_en && req.wr && !req.rd && !sel_write
      |=> $stable(instr_not_data_select_q))
    else $error("identification write changed state");

  a_write_reads_zero: assert property (
      clk_en && req.wr && !req.rd && req.priv && hit_any
      |=> rsp.valid && !rsp.undef && rsp.data == 32'h0000_0000)
    else $error("write answer wrong");

  a_valid_follows: assert property (
      clk_en
      |=> rsp.valid == $past(access))
    else $error("answer does not follow request");

  a_idle_quiet: assert property (
      clk_en && !access
      |=> !rsp.valid && !rsp.undef && rsp.data == 32'h0000_0000)
    else $error("idle cycle answered");

  a_freeze_hold: assert property (
      !clk_en
      |=> $stable(rsp) && $stable(instr_not_data_select_q))
    else $error("state moved while enable low");

  // Main scenarios.
  c_select_write: cover property (clk_en && sel_write);
  c_read_isize: cover property (clk_en && req.rd && req.priv && hit_size && is_icache);
  c_read_dsize: cover property (clk_en && req.rd && req.priv && hit_size && !is_icache);
  c_read_level: cover property (clk_en && req.rd && req.priv && hit_level);
  c_unpriv:     cover property (clk_en && access && !req.priv);

endmodule : cache_id_register_bank

`default_nettype wire

// ---- cache_id_pkg.sv ----
// Package for the cache identification register bank.
// Assumes a single core clock domain; shared by the bank and its tests.
package cache_id_pkg;

  // ----------------------------------------------------------------
  // Coprocessor register coordinates
  // ----------------------------------------------------------------
  localparam logic [2:0] OPC1_ISA   = 3'h0;
  localparam logic [2:0] OPC1_CACHE = 3'h1;
  localparam logic [2:0] OPC1_SEL   = 3'h2;
  localparam logic [3:0] CRN_ID     = 4'h0;
  localparam logic [3:0] CRM_ISA    = 4'h2;
  localparam logic [3:0] CRM_CACHE  = 4'h0;
  localparam logic [2:0] OPC2_ISA5  = 3'h5;
  localparam logic [2:0] OPC2_ISA6  = 3'h6;
  localparam logic [2:0] OPC2_ISA7  = 3'h7;
  localparam logic [2:0] OPC2_SIZE  = 3'h0;
  localparam logic [2:0] OPC2_LEVEL = 3'h1;
  localparam logic [2:0] OPC2_SEL   = 3'h0;

  // ----------------------------------------------------------------
  // Field values
  // ----------------------------------------------------------------
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  localparam logic [3:0]  ICACHE_ATTR   = 4'h2;
  localparam logic [3:0]  DCACHE_ATTR   = 4'h7;
  localparam logic [9:0]  DCACHE_ASSOC  = 10'h003;
  localparam logic [9:0]  ICACHE_ASSOC  = 10'h001;
  localparam logic [2:0]  LINE_LEN_VAL  = 3'h1;
  localparam logic [2:0]  LEVEL_ONE     = 3'h1;
  localparam logic [2:0]  CL1_SPLIT     = 3'h3;
  localparam logic [14:0] DSETS_4KB     = 15'h001F;
  localparam logic [14:0] ISETS_4KB     = 15'h003F;
  localparam int          SEL_IND_BIT   = 0;
  localparam logic        SEL_RESET     = 1'b0;

  // ----------------------------------------------------------------
  // Access carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       priv;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
  } cp_req_s;

  typedef struct packed {
    logic        valid;
    logic        undef;
    logic [31:0] data;
  } cp_rsp_s;

endpackage : cache_id_pkg

// ---- cache_id_register_bank_bench.sv ----
// Self-checking bench for the cache identification register bank.
// Assumes the answer comes one enabled edge after a request and freezes with clk_en low.
`timescale 1ns/1ps
`default_nettype none

module cache_id_register_bank_bench;
  import cache_id_pkg::*;

  // ----------------------------------------------------------------
  // Expected words; the sizes sit at both ends of the legal range
  // ----------------------------------------------------------------
  localparam int          I_KB    = 64;
  localparam int          D_KB    = 4;
  localparam logic [31:0] D_SIZE  = {4'h7, 15'h001F, 10'h003, 3'h1};
  localparam logic [31:0] I_SIZE  = {4'h2, 15'h03FF, 10'h001, 3'h1};
  localparam logic [31:0] LEVEL_W = {2'h0, 3'h1, 3'h1, 3'h1, 18'h0_0000, 3'h3};
  localparam int          CAP     = 2000;

  logic        core_clk;
  logic        rst;
  logic        clk_en;
  cp_req_s     req;
  logic [31:0] wr_data;
  cp_rsp_s     rsp;
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;

  cache_id_register_bank #(.ICACHE_KB(I_KB), .DCACHE_KB(D_KB)) dut (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .req(req), .wr_data(wr_data), .rsp(rsp));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // The request is cleared after its edge, so each access stands alone.
  task automatic acc(input string what, input logic w, input logic p, input logic [2:0] o1,
                     input logic [3:0] m, input logic [2:0] o2, input logic [31:0] wd,
                     input logic u, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    req = '{rd: !w, wr: w, priv: p, opc1: o1, crn: CRN_ID, crm: m, opc2: o2};
    wr_data = wd;
    @(posedge core_clk);
    #1;
    req = '0;
    check(what, {1'b1, u, d}, rsp);
  endtask : acc

  task automatic finish_test();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == CAP) begin
      mismatches++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    req = '0;
    wr_data = 32'h0000_0000;
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check("reset rsp", 34'h0_0000_0000, rsp);
    acc("isa5", 0, 1, OPC1_ISA, CRM_ISA, OPC2_ISA5, 0, 0, ZERO_WORD);
    acc("isa6", 0, 1, OPC1_ISA, CRM_ISA, OPC2_ISA6, 0, 0, ZERO_WORD);
    acc("isa7", 0, 1, OPC1_ISA, CRM_ISA, OPC2_ISA7, 0, 0, ZERO_WORD);
    acc("level", 0, 1, OPC1_CACHE, CRM_CACHE, OPC2_LEVEL, 0, 0, LEVEL_W);
    $display("Test isa and level words done");
    acc("size d", 0, 1, OPC1_CACHE, CRM_CACHE, OPC2_SIZE, 0, 0, D_SIZE);
    acc("sel wr", 1, 1, OPC1_SEL, CRM_CACHE, OPC2_SEL, 32'hFFFF_FFFF, 0, ZERO_WORD);
    acc("sel rd", 0, 1, OPC1_SEL, CRM_CACHE, OPC2_SEL, 0, 0, 32'h0000_0001);
    acc("size i", 0, 1, OPC1_CACHE, CRM_CACHE, OPC2_SIZE, 0, 0, I_SIZE);
    acc("sel wr0", 1, 1, OPC1_SEL, CRM_CACHE, OPC2_SEL, 32'hFFFF_FFFE, 0, ZERO_WORD);
    acc("size d2", 0, 1, OPC1_CACHE, CRM_CACHE, OPC2_SIZE, 0, 0, D_SIZE);
    $display("Test cache selection done");
    acc("size wr", 1, 1, OPC1_CACHE, CRM_CACHE, OPC2_SIZE, 32'hFFFF_FFFF, 0, ZERO_WORD);
    acc("size d3", 0, 1, OPC1_CACHE, CRM_CACHE, OPC2_SIZE, 0, 0, D_SIZE);
    acc("lvl wr", 1, 1, OPC1_CACHE, CRM_CACHE, OPC2_LEVEL, 32'hFFFF_FFFF, 0, ZERO_WORD);
    acc("level2", 0, 1, OPC1_CACHE, CRM_CACHE, OPC2_LEVEL, 0, 0, LEVEL_W);
    $display("Test write protection done");
    acc("user size", 0, 0, OPC1_CACHE, CRM_CACHE, OPC2_SIZE, 0, 1, ZERO_WORD);
    acc("user lvl", 0, 0, OPC1_CACHE, CRM_CACHE, OPC2_LEVEL, 0, 1, ZERO_WORD);
    acc("user isa5", 0, 0, OPC1_ISA, CRM_ISA, OPC2_ISA5, 0, 1, ZERO_WORD);
    acc("user sel", 1, 0, OPC1_SEL, CRM_CACHE, OPC2_SEL, 32'h0000_0001, 1, ZERO_WORD);
    acc("size d4", 0, 1, OPC1_CACHE, CRM_CACHE, OPC2_SIZE, 0, 0, D_SIZE);
    acc("unmapped", 0, 1, OPC1_ISA, CRM_ISA, 3'h4, 0, 1, ZERO_WORD);
    $display("Test privilege and decode done");
    // Back to back: a select write steers a size read at the very next edge.
    @(posedge core_clk);
    #1;
    req = '{rd: 1'b0, wr: 1'b1, priv: 1'b1, opc1: OPC1_SEL, crn: CRN_ID, crm: CRM_CACHE, opc2: OPC2_SEL};
    wr_data = 32'h0000_0001;
    @(posedge core_clk);
    #1;
    req = '{rd: 1'b1, wr: 1'b0, priv: 1'b1, opc1: OPC1_CACHE, crn: CRN_ID, crm: CRM_CACHE, opc2: OPC2_SIZE};
    wr_data = 32'h0000_0000;
    @(posedge core_clk);
    #1;
    req = '0;
    check("b2b size i", {1'b1, 1'b0, I_SIZE}, rsp);
    // Freeze: with the enable low the answer stands and a select write is lost.
    clk_en = 1'b0;
    req = '{rd: 1'b0, wr: 1'b1, priv: 1'b1, opc1: OPC1_SEL, crn: CRN_ID, crm: CRM_CACHE, opc2: OPC2_SEL};
    @(posedge core_clk);
    #1;
    check("frozen rsp", {1'b1, 1'b0, I_SIZE}, rsp);
    clk_en = 1'b1;
    req = '0;
    acc("size i2", 0, 1, OPC1_CACHE, CRM_CACHE, OPC2_SIZE, 0, 0, I_SIZE);
    $display("Test back to back and freeze done");
    finish_test();
  end

endmodule : cache_id_register_bank_bench

`default_nettype wire
